/* design/pivm_map.sv */
// Purpose: Map peripheral interrupt levels onto the core's user lines
// Assumes: Peripherals run on clk; the core fetches word vectors
// Notes:   Also answers vector address and priority queries
//
// Summary of operation
// - Addresses 0x00-0x3c are core exceptions; 32 user vectors 0x40-0xbc.
// - Vector word zero holds the initial stack pointer loaded at reset.
// - Reset, NMI, severe fault have fixed priorities -3,-2,-1 at 0x4-0xc.
// - Supervisor, pending service, tick priorities settable; reset 3,5,6.
// - Each used line from one peripheral; priority 0 after reset, settable except radio line 6.
// - GPIO drives line 0 (0x40), flash controller line 1 (0x44).
// - UART drives line 4 (0x50), SPI line 5 (0x54).
// - Radio controller drives line 6 (0x58); its priority is fixed critical.
// - Watchdog line 7, ADC 13, second I2C 14, first I2C 15.
// - Timer one A/B lines 17/18, timer two 19/20, RTC 21, key 22, DMA 23.
// - Lines 2,3,8-12,16,24-31 reserved, held inactive, no handler.
`timescale 1ns/1ps
`default_nettype none

module pivm_map
  import pivm_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    clk_en,
  input  wire pivm_periph_irq_s        periph_irq,
  input  wire logic [ADDR_W-1:0]       vec_query_addr,
  input  wire logic                    prio_wr,
  input  wire logic [4:0]              prio_wr_line,
  input  wire logic signed [PRIO_W-1:0] prio_wr_val,
  input  wire logic [1:0]              sys_prio_wr,
  input  wire logic signed [PRIO_W-1:0] sys_prio_val,
  output logic [NUM_USER_LINES-1:0]    user_irq,
  output logic                         vec_is_user,
  output logic                         vec_is_stack,
  output logic                         vec_has_handler,
  output logic [4:0]                   vec_line,
  output logic signed [PRIO_W-1:0]     vec_prio,
  output logic                         vec_prio_fixed
);

  // ----------------------------------------------------------------
  // Line routing
  // ----------------------------------------------------------------
  logic [NUM_USER_LINES-1:0] irq_d;
  logic [NUM_USER_LINES-1:0] irq_q;

  // Place each peripheral level on its user line
  always_comb
  begin
    irq_d = '0;
    irq_d[LINE_GPIO]    = periph_irq.gpio;
    irq_d[LINE_FLASH]   = periph_irq.flash;
    irq_d[LINE_UART]    = periph_irq.uart;
    irq_d[LINE_SPI]     = periph_irq.spi;
    irq_d[LINE_RADIO]   = periph_irq.radio;
    irq_d[LINE_WDOG]    = periph_irq.wdog;
    irq_d[LINE_ADC]     = periph_irq.adc;
    irq_d[LINE_I2C_TWO] = periph_irq.i2c_two;
    irq_d[LINE_I2C_ONE] = periph_irq.i2c_one;
    irq_d[LINE_TMR1_A]  = periph_irq.tmr1_a;
    irq_d[LINE_TMR1_B]  = periph_irq.tmr1_b;
    irq_d[LINE_TMR2_A]  = periph_irq.tmr2_a;
    irq_d[LINE_TMR2_B]  = periph_irq.tmr2_b;
    irq_d[LINE_RTC]     = periph_irq.rtc;
    irq_d[LINE_PKEY]    = periph_irq.pkey;
    irq_d[LINE_DMA]     = periph_irq.dma;
    irq_d = irq_d & USED_LINES_MASK;
  end

  // Register levels so the core sees clean clk-synchronous lines
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq_q <= '0;
    else if (clk_en)
      irq_q <= irq_d;
  end

  assign user_irq = irq_q;

  // ----------------------------------------------------------------
  // Priority state
  // ----------------------------------------------------------------
  logic signed [PRIO_W-1:0] uprio_d [NUM_USER_LINES];
  logic signed [PRIO_W-1:0] uprio_q [NUM_USER_LINES];
  logic signed [PRIO_W-1:0] sprio_d [3];
  logic signed [PRIO_W-1:0] sprio_q [3];

  // Software priority updates; critical and fixed entries ignore writes
  always_comb
  begin
    uprio_d = uprio_q;
    sprio_d = sprio_q;
    if (prio_wr && !CRIT_LINES_MASK[prio_wr_line])
      uprio_d[prio_wr_line] = prio_wr_val;
    if (sys_prio_wr != 2'h3)
      sprio_d[sys_prio_wr] = sys_prio_val;
  end

  // Priorities come back to their initial values at reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < NUM_USER_LINES; i++)
        uprio_q[i] <= PRIO_USER_INIT;
      sprio_q[0] <= PRIO_SUPERVISOR;
      sprio_q[1] <= PRIO_PENDING;
      sprio_q[2] <= PRIO_TICK;
    end
    else if (clk_en)
    begin
      uprio_q <= uprio_d;
      sprio_q <= sprio_d;
    end
  end

  // ----------------------------------------------------------------
  // Vector query decode
  // ----------------------------------------------------------------
  logic                     is_user_d;
  logic                     is_stack_d;
  logic                     handler_d;
  logic [4:0]               line_d;
  logic signed [PRIO_W-1:0] prio_d;
  logic                     fixed_d;

  // Classify the queried vector address and look up its priority
  always_comb
  begin
    is_user_d  = (vec_query_addr >= VEC_USER_BASE) &&
                 (vec_query_addr <= VEC_USER_LAST);
    is_stack_d = (vec_query_addr == VEC_STACK_PTR);
    line_d     = is_user_d ? vector_line(vec_query_addr) : 5'h0;
    handler_d  = 1'b0;
    prio_d     = PRIO_USER_INIT;
    fixed_d    = 1'b0;
    if (is_user_d)
    begin
      handler_d = USED_LINES_MASK[line_d];
      prio_d    = uprio_q[line_d];
      fixed_d   = CRIT_LINES_MASK[line_d];
    end
    else
    begin
      // Exception words carry a handler unless reserved or the stack word
      handler_d = 1'b1;
      fixed_d   = (vec_query_addr == VEC_RESET) ||
                  (vec_query_addr == VEC_NMI) ||
                  (vec_query_addr == VEC_SEVERE);
      unique case (vec_query_addr)
        VEC_RESET:       prio_d = PRIO_RESET;
        VEC_NMI:         prio_d = PRIO_NMI;
        VEC_SEVERE:      prio_d = PRIO_SEVERE;
        VEC_SUPERVISOR:  prio_d = sprio_q[0];
        VEC_PENDING_SRV: prio_d = sprio_q[1];
        VEC_TICK:        prio_d = sprio_q[2];
        default:         handler_d = 1'b0;
      endcase
    end
  end

  // Query answers come from flip-flops
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      vec_is_user     <= 1'b0;
      vec_is_stack    <= 1'b0;
      vec_has_handler <= 1'b0;
      vec_line        <= 5'h0;
      vec_prio        <= PRIO_USER_INIT;
      vec_prio_fixed  <= 1'b0;
    end
    else if (clk_en)
    begin
      vec_is_user     <= is_user_d;
      vec_is_stack    <= is_stack_d;
      vec_has_handler <= handler_d;
      vec_line        <= line_d;
      vec_prio        <= prio_d;
      vec_prio_fixed  <= fixed_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // One accepted write to a settable user line
  sequence s_user_prio_wr;
    clk_en && prio_wr && !CRIT_LINES_MASK[prio_wr_line];
  endsequence

  // One write attempt aimed at a critical line
  sequence s_crit_prio_wr;
    clk_en && prio_wr && CRIT_LINES_MASK[prio_wr_line];
  endsequence

  a_reserved_lines_idle: assert property (
    @(posedge clk) disable iff (sys_rst)
    (user_irq & ~USED_LINES_MASK) == '0)
    else $error("Reserved user line asserted");
  a_gpio_follows: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en |=> user_irq[LINE_GPIO] == $past(periph_irq.gpio))
    else $error("GPIO line mismatch");
  a_uart_follows: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en |=> user_irq[LINE_UART] == $past(periph_irq.uart))
    else $error("UART line mismatch");
  a_radio_follows: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en |=> user_irq[LINE_RADIO] == $past(periph_irq.radio))
    else $error("Radio line mismatch");
  a_wdog_follows: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en |=> user_irq[LINE_WDOG] == $past(periph_irq.wdog))
    else $error("Watchdog line mismatch");
  a_dma_follows: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en |=> user_irq[LINE_DMA] == $past(periph_irq.dma))
    else $error("DMA line mismatch");
  a_level_held: assert property (
    @(posedge clk) disable iff (sys_rst)
    !clk_en |=> $stable(user_irq))
    else $error("Lines moved while frozen");
  a_reset_prio_fixed: assert property (
    @(posedge clk) disable iff (sys_rst)
    (clk_en && vec_query_addr == VEC_RESET) |=>
      vec_prio == PRIO_RESET && vec_prio_fixed)
    else $error("Reset vector priority wrong");
  a_stack_word: assert property (
    @(posedge clk) disable iff (sys_rst)
    (clk_en && vec_query_addr == VEC_STACK_PTR) |=>
      vec_is_stack && !vec_has_handler)
    else $error("Stack word misdecoded");
  a_user_range: assert property (
    @(posedge clk) disable iff (sys_rst)
    (clk_en && vec_query_addr == VEC_USER_LAST) |=>
      vec_is_user && vec_line == 5'h1f)
    else $error("Last user vector misdecoded");
  a_prio_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    s_user_prio_wr |=> uprio_q[$past(prio_wr_line)] == $past(prio_wr_val))
    else $error("User priority not written");
  a_crit_prio_kept: assert property (
    @(posedge clk) disable iff (sys_rst)
    s_crit_prio_wr |=> $stable(uprio_q[LINE_RADIO]))
    else $error("Critical priority was changed");
  a_sys_prio_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    (clk_en && sys_prio_wr == 2'h0) |=> sprio_q[0] == $past(sys_prio_val))
    else $error("Supervisor priority not written");

endmodule

`default_nettype wire

/* design/pivm_pkg.sv */
// Purpose: Constants and types for the peripheral interrupt vector map
// Assumes: One 100 MHz system clock, synchronous active-high reset
// Notes:   Vector addresses are byte addresses of 32-bit table words
package pivm_pkg;

  // ----------------------------------------------------------------
  // Vector table layout
  // ----------------------------------------------------------------
  localparam int unsigned NUM_USER_LINES  = 32;
  localparam int unsigned ADDR_W          = 32;
  localparam int unsigned PRIO_W          = 4;
  localparam logic [31:0] VEC_STACK_PTR   = 32'h0000_0000;
  localparam logic [31:0] VEC_RESET       = 32'h0000_0004;
  localparam logic [31:0] VEC_NMI         = 32'h0000_0008;
  localparam logic [31:0] VEC_SEVERE      = 32'h0000_000c;
  localparam logic [31:0] VEC_SUPERVISOR  = 32'h0000_002c;
  localparam logic [31:0] VEC_PENDING_SRV = 32'h0000_0038;
  localparam logic [31:0] VEC_TICK        = 32'h0000_003c;
  localparam logic [31:0] VEC_USER_BASE   = 32'h0000_0040;
  localparam logic [31:0] VEC_USER_LAST   = 32'h0000_00bc;
  localparam logic [31:0] VEC_RSVD_FIRST  = 32'h0000_00a0;
  localparam int unsigned VEC_WORD_SHIFT  = 2;

  // ----------------------------------------------------------------
  // Exception priorities (signed, lower is more urgent)
  // ----------------------------------------------------------------
  localparam logic signed [PRIO_W-1:0] PRIO_RESET      = -4'sh3;
  localparam logic signed [PRIO_W-1:0] PRIO_NMI        = -4'sh2;
  localparam logic signed [PRIO_W-1:0] PRIO_SEVERE     = -4'sh1;
  localparam logic signed [PRIO_W-1:0] PRIO_SUPERVISOR = 4'sh3;
  localparam logic signed [PRIO_W-1:0] PRIO_PENDING    = 4'sh5;
  localparam logic signed [PRIO_W-1:0] PRIO_TICK       = 4'sh6;
  localparam logic signed [PRIO_W-1:0] PRIO_USER_INIT  = 4'sh0;

  // ----------------------------------------------------------------
  // User line positions
  // ----------------------------------------------------------------
  localparam int unsigned LINE_GPIO    = 0;
  localparam int unsigned LINE_FLASH   = 1;
  localparam int unsigned LINE_UART    = 4;
  localparam int unsigned LINE_SPI     = 5;
  localparam int unsigned LINE_RADIO   = 6;
  localparam int unsigned LINE_WDOG    = 7;
  localparam int unsigned LINE_ADC     = 13;
  localparam int unsigned LINE_I2C_TWO = 14;
  localparam int unsigned LINE_I2C_ONE = 15;
  localparam int unsigned LINE_TMR1_A  = 17;
  localparam int unsigned LINE_TMR1_B  = 18;
  localparam int unsigned LINE_TMR2_A  = 19;
  localparam int unsigned LINE_TMR2_B  = 20;
  localparam int unsigned LINE_RTC     = 21;
  localparam int unsigned LINE_PKEY    = 22;
  localparam int unsigned LINE_DMA     = 23;

  // Lines that carry a peripheral; all others are reserved
  localparam logic [31:0] USED_LINES_MASK = 32'h00fe_e0f3;
  // Critical lines whose priority software must not reassign
  localparam logic [31:0] CRIT_LINES_MASK = 32'h0000_0040;

  // Peripheral request levels grouped together
  typedef struct packed {
    logic gpio;
    logic flash;
    logic uart;
    logic spi;
    logic radio;
    logic wdog;
    logic adc;
    logic i2c_two;
    logic i2c_one;
    logic tmr1_a;
    logic tmr1_b;
    logic tmr2_a;
    logic tmr2_b;
    logic rtc;
    logic pkey;
    logic dma;
  } pivm_periph_irq_s;

  // Vector slot lookup from a user line
  function automatic logic [31:0] user_vector(input logic [4:0] line);
    user_vector = VEC_USER_BASE + {25'h0, line, 2'h0};
  endfunction

  // Line index from a user vector byte address
  function automatic logic [4:0] vector_line(input logic [31:0] addr);
    logic [31:0] off;
    off = addr - VEC_USER_BASE;
    vector_line = off[VEC_WORD_SHIFT +: 5];
  endfunction

endpackage

/* verification/pivm_core_model.sv */
// Purpose: Core-side model that fetches vector words from the map
// Assumes: Same clock as the map; fetch address changes after an edge
// Notes:   In pending mode it fetches the vector of the lowest set line
`timescale 1ns/1ps
`default_nettype none

module pivm_core_model
  import pivm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [31:0] user_irq,
  input  wire logic        use_pending,
  input  wire logic [31:0] req_addr,
  output logic [31:0]      vec_query_addr
);
  logic [31:0] fetch_d;

  // Lowest pending line wins, else the bench address is fetched
  always_comb
  begin
    fetch_d = req_addr;
    if (use_pending)
    begin
      for (int i = 31; i >= 0; i--)
      begin
        if (user_irq[i])
        begin
          fetch_d = 32'h0000_0040 + (32'(i) << 2);
        end
      end
    end
  end

  // Fetch address is launched just after the edge
  always_ff @(posedge clk)
  begin
    vec_query_addr <= fetch_d;
  end
endmodule

`default_nettype wire

/* verification/tb_top.sv */
// Purpose: Self-checking bench for the peripheral interrupt vector map
// Assumes: Inputs change by non-blocking assignment on the rising edge
// Notes:   Vector answers packed as user,stack,handler,fixed,line,prio
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import pivm_pkg::*;
;
  typedef struct packed {
    logic [31:0] addr;
    logic [12:0] exp;
  } pivm_tb_row_s;

  logic                    clk = 1'b0;
  logic                    sys_rst = 1'b1;
  logic                    clk_en = 1'b1;
  pivm_periph_irq_s        periph_irq = '0;
  logic                    prio_wr = 1'b0;
  logic [4:0]              prio_wr_line = 5'h00;
  logic signed [3:0]       prio_wr_val = 4'sh0;
  logic [1:0]              sys_prio_wr = 2'h3;
  logic signed [3:0]       sys_prio_val = 4'sh0;
  logic                    use_pending = 1'b0;
  logic [31:0]             req_addr = 32'h0000_0000;
  logic [31:0]             vec_query_addr;
  logic [31:0]             user_irq;
  logic                    vec_is_user;
  logic                    vec_is_stack;
  logic                    vec_has_handler;
  logic                    vec_prio_fixed;
  logic [4:0]              vec_line;
  logic signed [3:0]       vec_prio;
  logic [12:0]             vec_obs;
  logic [31:0]             all_mask;
  logic [31:0]             line_exp;
  int                      miscompares = 0;
  int                      checks = 0;
  int                      cycles = 0;
  int unsigned             line_tab [16] = '{0, 1, 4, 5, 6, 7, 13, 14, 15,
                                             17, 18, 19, 20, 21, 22, 23};
  pivm_tb_row_s            rows [13] = '{
    '{32'h0000_0000, {4'b0100, 5'h00, 4'h0}},
    '{32'h0000_0004, {4'b0011, 5'h00, 4'hd}},
    '{32'h0000_0008, {4'b0011, 5'h00, 4'he}},
    '{32'h0000_000c, {4'b0011, 5'h00, 4'hf}},
    '{32'h0000_002c, {4'b0010, 5'h00, 4'h3}},
    '{32'h0000_0038, {4'b0010, 5'h00, 4'h5}},
    '{32'h0000_003c, {4'b0010, 5'h00, 4'h6}},
    '{32'h0000_0040, {4'b1010, 5'h00, 4'h0}},
    '{32'h0000_0058, {4'b1011, 5'h06, 4'h0}},
    '{32'h0000_0048, {4'b1000, 5'h02, 4'h0}},
    '{32'h0000_0084, {4'b1010, 5'h11, 4'h0}},
    '{32'h0000_00a0, {4'b1000, 5'h18, 4'h0}},
    '{32'h0000_00bc, {4'b1000, 5'h1f, 4'h0}}
  };

  assign vec_obs = {vec_is_user, vec_is_stack, vec_has_handler,
                    vec_prio_fixed, vec_line, vec_prio};

  // Clock of 10 ns and cycle ceiling against hangs
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      final_report();
    end
  end

  pivm_map pivm_map_inst (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .periph_irq(periph_irq),
    .vec_query_addr(vec_query_addr), .prio_wr(prio_wr),
    .prio_wr_line(prio_wr_line), .prio_wr_val(prio_wr_val),
    .sys_prio_wr(sys_prio_wr), .sys_prio_val(sys_prio_val),
    .user_irq(user_irq), .vec_is_user(vec_is_user),
    .vec_is_stack(vec_is_stack), .vec_has_handler(vec_has_handler),
    .vec_line(vec_line), .vec_prio(vec_prio),
    .vec_prio_fixed(vec_prio_fixed));

  pivm_core_model pivm_core_model_inst (
    .clk(clk), .user_irq(user_irq), .use_pending(use_pending),
    .req_addr(req_addr), .vec_query_addr(vec_query_addr));

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Model fetch plus one registered answer, sampled mid-cycle
  task automatic settle();
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic query(input logic [31:0] a);
    @(posedge clk);
    req_addr <= a;
    settle();
  endtask

  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial
  begin
    all_mask = '0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[i])
    begin
      query(rows[i].addr);
      chk("vector", {19'h0, vec_obs}, {19'h0, rows[i].exp});
    end
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      periph_irq <= pivm_periph_irq_s'(16'h8000 >> i);
      settle();
      line_exp = 32'h1 << line_tab[i];
      all_mask |= line_exp;
      chk("line", user_irq, line_exp);
    end
    // All peripherals high: reserved lines stay low, levels hold
    @(posedge clk);
    periph_irq <= '1;
    settle();
    chk("all", user_irq, all_mask);
    settle();
    chk("held", user_irq, all_mask);
    // Frozen clock enable keeps the lines
    @(posedge clk);
    clk_en <= 1'b0;
    periph_irq <= '0;
    settle();
    chk("frozen", user_irq, all_mask);
    @(posedge clk);
    clk_en <= 1'b1;
    periph_irq <= 16'h3000;
    use_pending <= 1'b1;
    repeat (2) settle();
    chk("fetch", {19'h0, vec_obs}, {19'h0, 4'b1010, 5'h04, 4'h0});
    // Back-to-back priority writes, critical one dropped
    @(posedge clk);
    use_pending <= 1'b0;
    prio_wr <= 1'b1;
    prio_wr_line <= 5'h04;
    prio_wr_val <= 4'sh2;
    @(posedge clk);
    prio_wr_line <= 5'h06;
    prio_wr_val <= 4'sh5;
    @(posedge clk);
    prio_wr <= 1'b0;
    sys_prio_wr <= 2'h0;
    sys_prio_val <= 4'sh1;
    @(posedge clk);
    sys_prio_wr <= 2'h1;
    sys_prio_val <= 4'sh2;
    @(posedge clk);
    sys_prio_wr <= 2'h2;
    sys_prio_val <= 4'sh4;
    @(posedge clk);
    sys_prio_wr <= 2'h3;
    query(32'h0000_0050);
    chk("user prio", {19'h0, vec_obs}, {19'h0, 4'b1010, 5'h04, 4'h2});
    query(32'h0000_0058);
    chk("critical", {19'h0, vec_obs}, {19'h0, 4'b1011, 5'h06, 4'h0});
    query(32'h0000_002c);
    chk("super prio", {19'h0, vec_obs}, {19'h0, 4'b0010, 5'h00, 4'h1});
    query(32'h0000_0038);
    chk("pend prio", {19'h0, vec_obs}, {19'h0, 4'b0010, 5'h00, 4'h2});
    query(32'h0000_003c);
    chk("tick prio", {19'h0, vec_obs}, {19'h0, 4'b0010, 5'h00, 4'h4});
    // Reset in mid-run restores the start values
    @(posedge clk);
    sys_rst <= 1'b1;
    settle();
    chk("rst lines", user_irq, 32'h0);
    chk("rst query", {19'h0, vec_obs}, 32'h0);
    @(posedge clk);
    sys_rst <= 1'b0;
    periph_irq <= '0;
    query(32'h0000_002c);
    chk("rst super", {19'h0, vec_obs}, {19'h0, 4'b0010, 5'h00, 4'h3});
    query(32'h0000_003c);
    chk("rst tick", {19'h0, vec_obs}, {19'h0, 4'b0010, 5'h00, 4'h6});
    query(32'h0000_0050);
    chk("rst user", {19'h0, vec_obs}, {19'h0, 4'b1010, 5'h04, 4'h0});
    final_report();
  end
endmodule

`default_nettype wire
